/* File: include/mirq_pkg.sv */
// Purpose: shared constants of the interrupt control unit
// Assumes: 8-bit registers, one per aligned Wishbone word
// Notes:   offsets are byte addresses
package mirq_pkg;
	// ==========================================================
	// register byte offsets
	localparam logic [7:0] ADR_CTRL  = 8'h00;
	localparam logic [7:0] ADR_PFLG1 = 8'h04;
	localparam logic [7:0] ADR_PFLG2 = 8'h08;
	localparam logic [7:0] ADR_PMSK1 = 8'h0c;
	localparam logic [7:0] ADR_PMSK2 = 8'h10;
	localparam logic [7:0] ADR_OPT   = 8'h14;
	localparam logic [7:0] ADR_STAT  = 8'h18;
	// ==========================================================
	// control, option and status register fields
	localparam int GLB_BIT  = 7;
	localparam int GRP_BIT  = 6;
	localparam int TMSK_BIT = 5;
	localparam int XMSK_BIT = 4;
	localparam int CMSK_BIT = 3;
	localparam int TFLG_BIT = 2;
	localparam int XFLG_BIT = 1;
	localparam int CFLG_BIT = 0;
	localparam int EDGE_BIT = 6;
	localparam int STAT_HND_BIT = 0;
	localparam int STAT_SLP_BIT = 1;
	localparam int STAT_REQ_BIT = 2;
	// ==========================================================
	// reset values
	localparam logic [7:0]  CTRL_RESET = 8'h00;
	localparam logic [7:0]  OPT_RESET  = 8'hff;
	localparam logic [15:0] PREG_RESET = 16'h0000;
	// ==========================================================
	// vector, timer wrap, timing, peripheral source limit
	localparam logic [12:0] VECTOR_ADDR = 13'h0004;
	localparam logic [7:0]  TMR_TOP     = 8'hff;
	localparam logic [7:0]  TMR_WRAP    = 8'h00;
	localparam int CLKS_PER_INSTR = 4;
	localparam logic [1:0] LAT_TICKS = 2'h3;
	localparam int MAX_PERIPH = 12;
endpackage

/* File: design/mirq_evtdet.sv */
// Purpose: event detectors for pin edge, timer wrap, port change
// Assumes: all inputs synchronous to clk_i
// Notes:   no event in the first cycle after reset
`timescale 1ns/10ps
module mirq_evtdet (
	// clock and reset
	input  wire logic       clk_i,
	input  wire logic       rst_i,
	// sources
	input  wire logic       pin_i,
	input  wire logic       rise_sel_i,
	input  wire logic [7:0] tmr_i,
	input  wire logic [3:0] nib_i,
	// one-cycle events
	output wire logic       ext_evt_o,
	output wire logic       tmr_evt_o,
	output wire logic       port_evt_o
);
	// ==========================================================
	// history
	logic       vld_ff;
	logic       pin_q_ff;
	logic [7:0] tmr_q_ff;
	logic [3:0] nib_q_ff;

	// history is meaningless until one sample is taken
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			vld_ff   <= 1'b0;
			pin_q_ff <= 1'b0;
			tmr_q_ff <= 8'h00;
			nib_q_ff <= 4'h0;
		end else begin
			vld_ff   <= 1'b1;
			pin_q_ff <= pin_i;
			tmr_q_ff <= tmr_i;
			nib_q_ff <= nib_i;
		end
	end

	// ==========================================================
	// detectors
	wire rise_w = pin_i & ~pin_q_ff;
	wire fall_w = ~pin_i & pin_q_ff;
	assign ext_evt_o  = vld_ff & (rise_sel_i ? rise_w : fall_w); // [RULE_12]
	assign tmr_evt_o  = vld_ff & (tmr_q_ff == mirq_pkg::TMR_TOP)
		& (tmr_i == mirq_pkg::TMR_WRAP); // [RULE_16]
	assign port_evt_o = vld_ff & (nib_i != nib_q_ff); // [RULE_17]
endmodule

/* File: design/mirq_ctrl.sv */
// Purpose: interrupt control unit with Wishbone register access
// Assumes: core gives return and sleep, takes vector and wake
// Notes:   instruction rate is a divided enable of clk_i
//
// Overview of operation
// RULE_01 - up to fifteen sources, each flag plus enable
// RULE_02 - flags set whatever the enables say
// RULE_03 - global enable gates every vector
// RULE_04 - enabled flag with global enable vectors
// RULE_05 - any reset clears global enable
// RULE_06 - on vector: clear global, push, load 0004h
// RULE_07 - return-from-irq sets global enable again
// RULE_08 - core flags, enables, group enable in control
// RULE_09 - peripheral flags and masks in two pairs
// RULE_10 - handler clears flags before re-enabling
// RULE_11 - pin event to vector: three or four cycles
// RULE_12 - pin edge chosen by edge-select bit
// RULE_13 - pin edge sets pin flag, mask gates it
// RULE_14 - enabled pin request wakes regardless of global
// RULE_15 - after wake global enable decides branching
// RULE_16 - timer FFh to 00h sets overflow flag
// RULE_17 - upper port nibble change sets change flag
// RULE_18 - wake leaves a cause flag set
// RULE_19 - peripheral needs flag, mask, group, global
// RULE_20 - masks clear on reset, kept over sleep
`timescale 1ns/10ps
module mirq_ctrl #(
	parameter int NUM_PERIPH = 12,
	parameter int CLK_DIV    = mirq_pkg::CLKS_PER_INSTR
) (
	// clock and reset
	input  wire logic                  clk_i,
	input  wire logic                  rst_i,
	// wishbone slave
	input  wire logic                  cyc_i,
	input  wire logic                  stb_i,
	input  wire logic                  we_i,
	input  wire logic [7:0]            adr_i,
	input  wire logic [3:0]            sel_i,
	input  wire logic [31:0]           dat_i,
	output logic      [31:0]           dat_o,
	output logic                       ack_o,
	// sources
	input  wire logic                  ext_irq_pin_i,
	input  wire logic [7:0]            timer0_count_i,
	input  wire logic [7:0]            port_b_pins_i,
	input  wire logic [NUM_PERIPH-1:0] periph_evt_i,
	// core sequencer
	input  wire logic                  return_from_irq_op_i,
	input  wire logic                  sleep_i,
	output logic                       vector_o,
	output logic      [12:0]           vector_addr_o,
	output logic                       wake_o,
	output logic                       wake_branch_o,
	output logic                       instr_tick_o
);
	// ==========================================================
	// parameter checks
	if (NUM_PERIPH < 1 || NUM_PERIPH > mirq_pkg::MAX_PERIPH) begin
		$error("NUM_PERIPH out of range");
	end
	// latency window of the checks must stay within 1000 cycles
	if (CLK_DIV < 2 || CLK_DIV > 250) begin
		$error("CLK_DIV out of range");
	end

	// ==========================================================
	// state
	logic [7:0]  ctrl_ff;
	logic [7:0]  opt_ff;
	logic [15:0] pflag_ff;
	logic [15:0] pmask_ff;
	logic [7:0]  div_ff;
	logic [1:0]  lat_ff;
	logic        hnd_ff;
	logic        ack_ff;
	logic [7:0]  nxt_ctrl;
	logic [15:0] nxt_pflag;
	logic [15:0] nxt_pmask;

	// ==========================================================
	// event detection
	wire ext_evt;
	wire tmr_evt;
	wire port_evt;

	mirq_evtdet u_evt (
		.clk_i      (clk_i),
		.rst_i      (rst_i),
		.pin_i      (ext_irq_pin_i),
		.rise_sel_i (opt_ff[mirq_pkg::EDGE_BIT]),
		.tmr_i      (timer0_count_i),
		.nib_i      (port_b_pins_i[7:4]),
		.ext_evt_o  (ext_evt),
		.tmr_evt_o  (tmr_evt),
		.port_evt_o (port_evt)
	);

	// ==========================================================
	// bus decode
	wire bus_req  = cyc_i & stb_i & ~ack_ff;
	wire wr_en    = bus_req & we_i & sel_i[0];
	wire wr_ctrl  = wr_en & (adr_i == mirq_pkg::ADR_CTRL);
	wire wr_pflg1 = wr_en & (adr_i == mirq_pkg::ADR_PFLG1);
	wire wr_pflg2 = wr_en & (adr_i == mirq_pkg::ADR_PFLG2);
	wire wr_pmsk1 = wr_en & (adr_i == mirq_pkg::ADR_PMSK1);
	wire wr_pmsk2 = wr_en & (adr_i == mirq_pkg::ADR_PMSK2);
	wire wr_opt   = wr_en & (adr_i == mirq_pkg::ADR_OPT);

	// ==========================================================
	// request logic
	wire glb_en = ctrl_ff[mirq_pkg::GLB_BIT];
	wire grp_en = ctrl_ff[mirq_pkg::GRP_BIT];
	wire core_hit =
		(ctrl_ff[mirq_pkg::TMSK_BIT] & ctrl_ff[mirq_pkg::TFLG_BIT])
		| (ctrl_ff[mirq_pkg::XMSK_BIT] & ctrl_ff[mirq_pkg::XFLG_BIT])
		| (ctrl_ff[mirq_pkg::CMSK_BIT] & ctrl_ff[mirq_pkg::CFLG_BIT]);
	wire p_hit    = |(pflag_ff & pmask_ff);
	wire wake_hit = core_hit | (grp_en & p_hit); // [RULE_19]
	// a pending request waits for the core to be awake
	wire req      = glb_en & wake_hit & ~sleep_i; // [RULE_03] [RULE_04]
	wire tick     = (div_ff == 8'(CLK_DIV - 1));
	// first tick after the event ends a partial cycle: 3 or 4 total
	wire take     = req & tick & (lat_ff == mirq_pkg::LAT_TICKS); // [RULE_11]
	wire ret_op   = return_from_irq_op_i;

	// ==========================================================
	// control register next value
	always_comb begin
		nxt_ctrl = wr_ctrl ? dat_i[7:0] : ctrl_ff; // [RULE_08]
		// hardware set wins over a software clear
		if (tmr_evt) begin
			nxt_ctrl[mirq_pkg::TFLG_BIT] = 1'b1; // [RULE_16] [RULE_02]
		end
		if (ext_evt) begin
			nxt_ctrl[mirq_pkg::XFLG_BIT] = 1'b1; // [RULE_13] [RULE_02]
		end
		if (port_evt) begin
			nxt_ctrl[mirq_pkg::CFLG_BIT] = 1'b1; // [RULE_17] [RULE_02]
		end
		if (ret_op) begin
			nxt_ctrl[mirq_pkg::GLB_BIT] = 1'b1; // [RULE_07]
		end
		if (take) begin
			nxt_ctrl[mirq_pkg::GLB_BIT] = 1'b0; // [RULE_06]
		end
	end

	// ==========================================================
	// peripheral flags and masks, one bit per source
	wire [15:0] pflag_wr = {
		wr_pflg2 ? dat_i[7:0] : pflag_ff[15:8],
		wr_pflg1 ? dat_i[7:0] : pflag_ff[7:0]};
	wire [15:0] pmask_wr = {
		wr_pmsk2 ? dat_i[7:0] : pmask_ff[15:8],
		wr_pmsk1 ? dat_i[7:0] : pmask_ff[7:0]};

	for (genvar i = 0; i < 16; i++) begin : g_src
		if (i < NUM_PERIPH) begin : g_used
			assign nxt_pflag[i] = pflag_wr[i] | periph_evt_i[i]; // [RULE_09] [RULE_02]
			assign nxt_pmask[i] = pmask_wr[i]; // [RULE_01]
		end else begin : g_none
			assign nxt_pflag[i] = 1'b0;
			assign nxt_pmask[i] = 1'b0;
		end
	end

	// ==========================================================
	// registers
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ctrl_ff  <= mirq_pkg::CTRL_RESET; // [RULE_05]
			opt_ff   <= mirq_pkg::OPT_RESET;
			pflag_ff <= mirq_pkg::PREG_RESET;
			pmask_ff <= mirq_pkg::PREG_RESET; // [RULE_20]
		end else begin
			ctrl_ff  <= nxt_ctrl;
			opt_ff   <= wr_opt ? dat_i[7:0] : opt_ff;
			pflag_ff <= nxt_pflag;
			pmask_ff <= nxt_pmask;
		end
	end

	// instruction divider and latency counter
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			div_ff <= 8'h00;
			lat_ff <= 2'h0;
		end else begin
			div_ff <= tick ? 8'h00 : div_ff + 8'h01;
			if (!req) begin
				lat_ff <= 2'h0;
			end else if (tick && lat_ff != mirq_pkg::LAT_TICKS) begin
				lat_ff <= lat_ff + 2'h1;
			end
		end
	end

	// ==========================================================
	// core outputs
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			vector_o      <= 1'b0;
			vector_addr_o <= mirq_pkg::VECTOR_ADDR;
			wake_o        <= 1'b0;
			wake_branch_o <= 1'b0;
			instr_tick_o  <= 1'b0;
			hnd_ff        <= 1'b0;
		end else begin
			vector_o      <= take; // [RULE_06]
			vector_addr_o <= mirq_pkg::VECTOR_ADDR;
			wake_o        <= sleep_i & wake_hit; // [RULE_14] [RULE_18]
			wake_branch_o <= sleep_i & wake_hit & glb_en; // [RULE_15]
			instr_tick_o  <= tick;
			hnd_ff        <= take | (hnd_ff & ~ret_op);
		end
	end

	// ==========================================================
	// read path
	wire [7:0] stat_w = {5'h00, req, sleep_i, hnd_ff};
	wire [7:0] rd_mux =
		(adr_i == mirq_pkg::ADR_CTRL)  ? ctrl_ff :
		(adr_i == mirq_pkg::ADR_PFLG1) ? pflag_ff[7:0] :
		(adr_i == mirq_pkg::ADR_PFLG2) ? pflag_ff[15:8] :
		(adr_i == mirq_pkg::ADR_PMSK1) ? pmask_ff[7:0] :
		(adr_i == mirq_pkg::ADR_PMSK2) ? pmask_ff[15:8] :
		(adr_i == mirq_pkg::ADR_OPT)   ? opt_ff :
		(adr_i == mirq_pkg::ADR_STAT)  ? stat_w : 8'h00;

	// unmapped addresses still ack, reading zero
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ack_ff <= 1'b0;
			dat_o  <= 32'h0000_0000;
		end else begin
			ack_ff <= bus_req;
			dat_o  <= bus_req ? {24'h00_0000, rd_mux} : 32'h0000_0000;
		end
	end
	assign ack_o = ack_ff;

	// ==========================================================
	// checks
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (rst_i);

	property p_vec_entry;
		vector_o |-> !glb_en && hnd_ff && vector_addr_o == 13'h0004;
	endproperty
	a_vec_entry: assert property (p_vec_entry) // [RULE_06]
		else $error("vector without global clear or address");

	property p_block;
		!glb_en |=> !vector_o;
	endproperty
	a_block: assert property (p_block) // [RULE_03]
		else $error("vector while global enable clear");

	property p_ret;
		ret_op && !take |=> glb_en;
	endproperty
	a_ret: assert property (p_ret) // [RULE_07]
		else $error("return did not set global enable");

	property p_rst;
		@(posedge clk_i) disable iff (1'b0)
		rst_i |=> !glb_en && pmask_ff == 16'h0000;
	endproperty
	a_rst: assert property (p_rst) // [RULE_05]
		else $error("reset left enables set");

	property p_pin;
		ext_evt |=> ctrl_ff[mirq_pkg::XFLG_BIT];
	endproperty
	a_pin: assert property (p_pin) // [RULE_13]
		else $error("pin edge lost");

	property p_tmr;
		tmr_evt |=> ctrl_ff[mirq_pkg::TFLG_BIT];
	endproperty
	a_tmr: assert property (p_tmr) // [RULE_16]
		else $error("timer wrap lost");

	property p_port;
		port_evt |=> ctrl_ff[mirq_pkg::CFLG_BIT];
	endproperty
	a_port: assert property (p_port) // [RULE_17]
		else $error("port change lost");

	property p_pflag;
		periph_evt_i[0] |=> pflag_ff[0];
	endproperty
	a_pflag: assert property (p_pflag) // [RULE_02]
		else $error("peripheral event lost");

	property p_wake;
		sleep_i && core_hit |=> wake_o;
	endproperty
	a_wake: assert property (p_wake) // [RULE_14]
		else $error("no wake on enabled request");

	// assumes the request holds until taken: a drop restarts the count
	localparam int LAT_LO = 3 * CLK_DIV;
	localparam int LAT_HI = 4 * CLK_DIV;
	property p_lat;
		$rose(req) |-> ##[LAT_LO:LAT_HI] vector_o;
	endproperty
	a_lat: assert property (p_lat) // [RULE_11]
		else $error("latency out of range");

	c_vec: cover property (vector_o);
	c_wake: cover property (wake_branch_o);
	c_ret: cover property (hnd_ff ##1 !hnd_ff);
	c_sleep: cover property (sleep_i && wake_o);
	c_grp: cover property (grp_en && p_hit && vector_o);

	// bus answers are single pulses with data only under ack
	property p_ack_pulse;
		ack_o |=> !ack_o;
	endproperty
	a_ack_pulse: assert property (p_ack_pulse) // [RULE_08]
		else $error("ack held longer than one cycle");

	property p_rd_idle;
		!ack_o |-> dat_o == 32'h0000_0000;
	endproperty
	a_rd_idle: assert property (p_rd_idle) // [RULE_08]
		else $error("read data outside ack");

	property p_wake_br;
		wake_branch_o |-> wake_o;
	endproperty
	a_wake_br: assert property (p_wake_br) // [RULE_15]
		else $error("branch request without wake");

	// the core cannot take a vector while asleep
	property p_sleep_novec;
		sleep_i |=> !vector_o;
	endproperty
	a_sleep_novec: assert property (p_sleep_novec) // [RULE_15]
		else $error("vector while asleep");

	property p_ret_hnd;
		ret_op && !take |=> !hnd_ff;
	endproperty
	a_ret_hnd: assert property (p_ret_hnd) // [RULE_07]
		else $error("handler state kept after return");

	property p_tick;
		instr_tick_o |=> !instr_tick_o;
	endproperty
	a_tick: assert property (p_tick) // [RULE_11]
		else $error("instruction tick longer than one cycle");
endmodule

/* File: sim/mirq_core_model.sv */
// Purpose: core sequencer stand-in facing the interrupt unit
// Assumes: bench requests are one-cycle pulses or levels
// Notes:   counts vectors so the bench can judge entries
`timescale 1ns/10ps
module mirq_core_model (
	// clock and reset
	input  wire logic       clk_i,
	input  wire logic       rst_i,
	// bench requests
	input  wire logic       ret_req_i,
	input  wire logic       sleep_req_i,
	// unit side
	input  wire logic       vector_i,
	output logic            return_from_irq_op_o,
	output logic            sleep_o,
	output logic [7:0]      n_vec_o
);
	// ==========
	// sequencer
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			return_from_irq_op_o <= 1'b0;
			sleep_o              <= 1'b0;
			n_vec_o              <= 8'h00;
		end else begin
			// registered, as the real core acts a cycle late
			return_from_irq_op_o <= ret_req_i;
			sleep_o              <= sleep_req_i;
			n_vec_o              <= n_vec_o + {7'h00, vector_i};
		end
	end
endmodule

/* File: sim/mirq_ctrl_tb.sv */
// Purpose: self-checking bench of the interrupt unit
// Assumes: one wishbone ack per request, CLK_DIV of 4
// Notes:   vector entries are counted by the core model
`timescale 1ns/10ps
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin \
	n_mismatch++; $display("unexpected at %0t: got %h exp %h", \
	$time, (g), (e)); end end
module mirq_ctrl_tb;
	// ==========
	// signals
	logic        clk_i = 1'b0;
	logic        rst_i = 1'b1;
	logic        cyc_i = 1'b0;
	logic        stb_i = 1'b0;
	logic        we_i  = 1'b0;
	logic [7:0]  adr_i = 8'h00;
	logic [3:0]  sel_i = 4'h0;
	logic [31:0] dat_i = 32'h0000_0000;
	logic        pin   = 1'b0;
	logic [7:0]  tmr   = 8'h00;
	logic [7:0]  port_pins = 8'h00;
	logic [11:0] pevt  = 12'h000;
	logic        ret_req = 1'b0;
	logic        slp_req = 1'b0;
	wire  logic [31:0] dat_o;
	wire  logic [12:0] vaddr;
	wire  logic [7:0]  n_vec;
	wire  logic        ack_o, vec, wake, wbr, ret, slp, tick_o;
	int          n_mismatch  = 0;
	int          check_count = 0;
	int          cyc_cnt     = 0;
	always #5 clk_i = ~clk_i;
	mirq_ctrl #(.NUM_PERIPH(12), .CLK_DIV(4)) dut (.clk_i(clk_i),
		.rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
		.adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o),
		.ack_o(ack_o), .ext_irq_pin_i(pin), .timer0_count_i(tmr),
		.port_b_pins_i(port_pins), .periph_evt_i(pevt),
		.return_from_irq_op_i(ret), .sleep_i(slp), .vector_o(vec),
		.vector_addr_o(vaddr), .wake_o(wake), .wake_branch_o(wbr),
		.instr_tick_o(tick_o));
	mirq_core_model core (.clk_i(clk_i), .rst_i(rst_i),
		.ret_req_i(ret_req), .sleep_req_i(slp_req), .vector_i(vec),
		.return_from_irq_op_o(ret), .sleep_o(slp), .n_vec_o(n_vec));
	// ==========
	// shared tasks
	task automatic idle(input int n);
		repeat (n) @(posedge clk_i);
	endtask
	task automatic wb(input logic w, input logic [7:0] a,
		input logic [7:0] d, input logic [3:0] s, output logic [7:0] q);
		cyc_i <= 1'b1; stb_i <= 1'b1; we_i <= w; adr_i <= a;
		sel_i <= s; dat_i <= {24'h00_0000, d};
		// no own limit: only the bench watchdog ends a hung wait
		@(posedge clk_i);
		while (ack_o !== 1'b1) begin
			@(posedge clk_i);
		end
		`CHK(ack_o, 1'b1)
		q = dat_o[7:0];
		cyc_i <= 1'b0; stb_i <= 1'b0;
		@(posedge clk_i);
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		logic [7:0] q;
		wb(1'b1, a, d, 4'hf, q);
	endtask
	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		logic [7:0] q;
		wb(1'b0, a, 8'h00, 4'hf, q);
		`CHK(q, e)
	endtask
	task automatic do_reset;
		rst_i <= 1'b1;
		idle(8);
		rst_i <= 1'b0;
		@(posedge clk_i);
	endtask
	task automatic tally_and_finish;
		$display("checks %0d mismatches %0d", check_count, n_mismatch);
		if (n_mismatch == 0 && check_count > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask
	// ==========
	// scenarios
	task automatic t_reset;
		logic [7:0] q;
		int n;
		rd(mirq_pkg::ADR_CTRL, 8'h00);
		rd(mirq_pkg::ADR_OPT, 8'hff);
		rd(mirq_pkg::ADR_PMSK2, 8'h00);
		wb(1'b1, mirq_pkg::ADR_PMSK1, 8'hff, 4'he, q);
		rd(mirq_pkg::ADR_PMSK1, 8'h00);
		rd(8'h1c, 8'h00);
		`CHK(vaddr, 13'h0004)
		// four clocks per instruction: two ticks in eight clocks
		n = 0;
		repeat (8) begin
			@(posedge clk_i);
			if (tick_o === 1'b1) n++;
		end
		`CHK(n, 2)
	endtask
	task automatic t_flags;
		pin <= 1'b1; idle(4);
		rd(mirq_pkg::ADR_CTRL, 8'h02);
		wr(mirq_pkg::ADR_CTRL, 8'h00);
		wr(mirq_pkg::ADR_OPT, 8'hbf);
		pin <= 1'b0; idle(4);
		rd(mirq_pkg::ADR_CTRL, 8'h02);
		tmr <= 8'hfe; idle(2); tmr <= 8'hff; idle(1); tmr <= 8'h00; idle(4);
		rd(mirq_pkg::ADR_CTRL, 8'h06);
		port_pins <= 8'h0f; idle(4);
		rd(mirq_pkg::ADR_CTRL, 8'h06);
		port_pins <= 8'h1f; idle(4);
		rd(mirq_pkg::ADR_CTRL, 8'h07);
		`CHK(n_vec, 8'h00)
	endtask
	task automatic t_vector;
		int n;
		wr(mirq_pkg::ADR_CTRL, 8'h97);
		for (n = 1; n < 30; n++) begin
			@(posedge clk_i);
			if (vec === 1'b1) break;
		end
		`CHK(n >= 11 && n <= 17, 1'b1)
		idle(1);
		`CHK(n_vec, 8'h01)
		rd(mirq_pkg::ADR_CTRL, 8'h17);
		rd(mirq_pkg::ADR_STAT, 8'h01);
		wr(mirq_pkg::ADR_CTRL, 8'h10);
		ret_req <= 1'b1; @(posedge clk_i); ret_req <= 1'b0; idle(3);
		rd(mirq_pkg::ADR_CTRL, 8'h90);
		rd(mirq_pkg::ADR_STAT, 8'h00);
		idle(20);
		`CHK(n_vec, 8'h01)
	endtask
	task automatic t_periph;
		wr(mirq_pkg::ADR_PMSK1, 8'h01);
		wr(mirq_pkg::ADR_PMSK2, 8'h0a);
		rd(mirq_pkg::ADR_PMSK2, 8'h0a);
		pevt <= 12'h001; @(posedge clk_i); pevt <= 12'h000; idle(20);
		rd(mirq_pkg::ADR_PFLG1, 8'h01);
		`CHK(n_vec, 8'h01)
		wr(mirq_pkg::ADR_CTRL, 8'hd0); idle(25);
		`CHK(n_vec, 8'h02)
		idle(25);
		`CHK(n_vec, 8'h02)
		wr(mirq_pkg::ADR_PFLG1, 8'h00);
		wr(mirq_pkg::ADR_PMSK1, 8'h00);
	endtask
	task automatic t_sleep;
		wr(mirq_pkg::ADR_CTRL, 8'h10);
		slp_req <= 1'b1; idle(3);
		`CHK(wake, 1'b0)
		pin <= 1'b1; idle(2); pin <= 1'b0; idle(4);
		`CHK(wake, 1'b1)
		`CHK(wbr, 1'b0)
		rd(mirq_pkg::ADR_CTRL, 8'h12);
		wr(mirq_pkg::ADR_CTRL, 8'h92); idle(2);
		`CHK(wbr, 1'b1)
		`CHK(n_vec, 8'h02)
		slp_req <= 1'b0; idle(25);
		`CHK(n_vec, 8'h03)
	endtask
	// ==========
	// run and watchdog
	always @(posedge clk_i) begin
		cyc_cnt++;
		if (cyc_cnt == 5000) begin
			n_mismatch++;
			tally_and_finish();
		end
	end
	initial begin
		do_reset();
		t_reset();
		t_flags();
		t_vector();
		t_periph();
		t_sleep();
		do_reset();
		t_reset();
		tally_and_finish();
	end
endmodule
